// ### tb/scirq_handler_model.sv
// interrupt handler model standing where the processor's handler sits
// assumes sysctl_irq is a level on clk_sys and that its clear request is or-ed into clear_strobe
`timescale 1ns/1ps
`default_nettype none
module scirq_handler_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic handler_en,
    input wire logic sysctl_irq,
    output logic clear_req,
    output logic [7:0] entries
);
    logic clear_ff;
    logic [7:0] entries_ff;
    logic entering;

    // the clear lands an edge later, so a still-high line right after a clear is not a new entry
    assign entering = handler_en && sysctl_irq && !clear_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            clear_ff <= 1'b0;
            entries_ff <= 8'h00;
        end else begin
            // clear is the first action on entry, not the last
            clear_ff <= entering;
            if (entering) begin
                entries_ff <= entries_ff + 8'h01;
            end
        end
    end
    assign clear_req = clear_ff;
    assign entries = entries_ff;
endmodule
`default_nettype wire

// ### tb/system_control_irq_supervisor_test.sv
// self-checking bench for the supervisor: events, mask, status, verify timers, regulator, gating
// assumes the design's one-edge latencies as handed over; ticks come from a free counter here
`timescale 1ns/1ps
`default_nettype none
module system_control_irq_supervisor_test;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    scirq_pkg::scirq_src_t hw_events = '0;
    scirq_pkg::scirq_src_t status_view;
    logic [6:0] tb_mask = 7'h00;
    logic [8:0] strb = 9'h000;
    logic msel = 1'b0;
    logic feature_enable_flag = 1'b0;
    logic regulator_fault_resets = 1'b0;
    logic regulator_unregulated = 1'b0;
    logic [3:0] regulator_voltage_choice = 4'h0;
    logic in_sleep = 1'b0;
    logic in_deep_sleep = 1'b0;
    logic [1:0] osc_run = 2'b11;
    logic [1:0] tick_on = 2'b11;
    logic main_osc_tick = 1'b0;
    logic int_osc_tick = 1'b0;
    logic handler_en = 1'b0;
    logic h_clear;
    logic [7:0] entries;
    logic sysctl_irq;
    logic regulator_reset_req;
    logic [3:0] regulator_voltage_code;
    logic [7:0] periph_clk_en;
    int bad_count = 0;
    int num_checks = 0;
    int cyc_count = 0;
    int tcnt = 0;
    int i;

    always #12.5 clk_sys = ~clk_sys;

    scirq_supervisor DUT (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .hw_events(hw_events),
        .source_bit_mask(h_clear ? 7'h7f : tb_mask),
        .clear_strobe(strb[0] | h_clear),
        .enable_strobe(strb[1]),
        .disable_strobe(strb[2]),
        .masked_view_select(msel),
        .status_view(status_view),
        .sysctl_irq(sysctl_irq),
        .iosc_verify_wr(strb[3]),
        .mosc_verify_wr(strb[4]),
        .feature_enable_flag(feature_enable_flag),
        .verify_clear_strobe(strb[5]),
        .main_osc_running(osc_run[0]),
        .int_osc_running(osc_run[1]),
        .main_osc_tick(main_osc_tick),
        .int_osc_tick(int_osc_tick),
        .regulator_cfg_wr(strb[6]),
        .regulator_fault_resets(regulator_fault_resets),
        .regulator_unregulated(regulator_unregulated),
        .regulator_reset_req(regulator_reset_req),
        .voltage_wr(strb[7]),
        .regulator_voltage_choice(regulator_voltage_choice),
        .regulator_voltage_code(regulator_voltage_code),
        .gating_wr(strb[8]),
        .in_sleep(in_sleep),
        .in_deep_sleep(in_deep_sleep),
        .run_en(8'h0f),
        .sleep_en(8'h33),
        .deep_sleep_en(8'h55),
        .periph_clk_en(periph_clk_en)
    );

    scirq_handler_model u_handler (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .handler_en(handler_en),
        .sysctl_irq(sysctl_irq),
        .clear_req(h_clear),
        .entries(entries)
    );

    // main ticks every 4 cycles, internal every 3, so neither can mask the other's silence
    always @(posedge clk_sys) begin
        tcnt <= tcnt + 1;
        main_osc_tick <= tick_on[0] && (tcnt % 4 == 0);
        int_osc_tick <= tick_on[1] && (tcnt % 3 == 1);
    end

    task end_sim;
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 20000) begin
            bad_count++;
            end_sim;
        end
    end

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // sel: 0 clear, 1 enable, 2 disable, 3/4 verify enables, 5 rearm, 6 regulator, 7 volt, 8 gate
    task ctl(input int sel, input logic [6:0] m);
        @(posedge clk_sys);
        tb_mask <= m;
        feature_enable_flag <= m[0];
        regulator_fault_resets <= m[0];
        regulator_voltage_choice <= m[3:0];
        strb <= 9'h001 << sel;
        @(posedge clk_sys);
        strb <= 9'h000;
    endtask

    task pulse(input logic [6:0] b);
        @(posedge clk_sys);
        hw_events <= scirq_pkg::scirq_src_t'(b);
        @(posedge clk_sys);
        hw_events <= '0;
    endtask

    task rd(input logic s, input logic [6:0] e);
        @(posedge clk_sys);
        msel <= s;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk({1'b0, status_view}, {1'b0, e});
    endtask

    task gate(input logic s, input logic d, input logic [7:0] e);
        @(posedge clk_sys);
        in_sleep <= s;
        in_deep_sleep <= d;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk(periph_clk_en, e);
    endtask

    task wait_irq(output int n);
        n = 0;
        @(negedge clk_sys);
        while (sysctl_irq !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    // t = 0 checks the internal timer (main is reference), t = 1 the main timer
    task osc(input int t);
        int n;
        logic [6:0] b;
        b = 7'h04 << t;
        ctl(3 + t, 7'h01);
        @(posedge clk_sys);
        tick_on[1 - t] <= 1'b0;
        wait_irq(n);
        chk(n >= (t ? 18 : 24) && n < 100, 1'b1);
        rd(0, b);
        ctl(0, b);
        repeat (60) @(negedge clk_sys);
        chk(sysctl_irq, 1'b0);
        ctl(5, 7'h00);
        wait_irq(n);
        chk(n < 100, 1'b1);
        @(posedge clk_sys);
        osc_run[t] <= 1'b0;
        ctl(5, 7'h00);
        ctl(0, b);
        repeat (60) @(negedge clk_sys);
        chk(sysctl_irq, 1'b0);
        ctl(3 + t, 7'h00);
        @(posedge clk_sys);
        osc_run[t] <= 1'b1;
        ctl(5, 7'h00);
        ctl(0, b);
        repeat (60) @(negedge clk_sys);
        chk(sysctl_irq, 1'b0);
        @(posedge clk_sys);
        tick_on[1 - t] <= 1'b1;
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(regulator_voltage_code, 8'h05);
        chk({1'b0, status_view}, 8'h00);
        chk(sysctl_irq, 1'b0);
        chk(regulator_reset_req, 1'b0);
        chk(periph_clk_en, 8'h00);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        for (i = 0; i < 7; i++) begin
            pulse(7'h01 << i);
        end
        rd(0, 7'h7f);
        chk(sysctl_irq, 1'b0);
        rd(1, 7'h00);
        ctl(1, 7'h25);
        @(negedge clk_sys);
        chk(sysctl_irq, 1'b1);
        rd(1, 7'h25);
        ctl(2, 7'h05);
        rd(1, 7'h20);
        ctl(0, 7'h50);
        rd(0, 7'h2f);
        ctl(0, 7'h0f);
        @(negedge clk_sys);
        chk(sysctl_irq, 1'b1);
        ctl(0, 7'h20);
        @(negedge clk_sys);
        chk(sysctl_irq, 1'b0);
        rd(0, 7'h00);
        // an event in the same cycle as its clear must survive
        fork
            pulse(7'h01);
            ctl(0, 7'h01);
        join
        rd(0, 7'h01);
        ctl(0, 7'h01);
        ctl(1, 7'h7f);
        @(posedge clk_sys);
        handler_en <= 1'b1;
        pulse(7'h40);
        repeat (6) @(negedge clk_sys);
        chk(entries, 8'h01);
        chk(sysctl_irq, 1'b0);
        @(posedge clk_sys);
        handler_en <= 1'b0;
        ctl(2, 7'h73);
        ctl(6, 7'h01);
        @(posedge clk_sys);
        regulator_unregulated <= 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(regulator_reset_req, 1'b1);
        ctl(6, 7'h00);
        repeat (2) @(negedge clk_sys);
        chk(regulator_reset_req, 1'b0);
        for (i = 0; i < 12; i++) begin
            ctl(7, i[6:0]);
            @(negedge clk_sys);
            chk(regulator_voltage_code, (i > 10) ? 8'h0a : i[7:0]);
        end
        gate(1, 0, 8'h0f);
        gate(0, 1, 8'h0f);
        ctl(8, 7'h01);
        gate(0, 1, 8'h55);
        gate(1, 0, 8'h33);
        gate(0, 0, 8'h0f);
        ctl(8, 7'h00);
        gate(0, 1, 8'h0f);
        osc(0);
        osc(1);
        end_sim;
    end
endmodule
`default_nettype wire

// ### verilog/scirq_clk_gate_sel.sv
// per-peripheral clock enable selection for run, sleep and deep-sleep
// assumes the power mode inputs are steady levels from the power controller
`timescale 1ns/1ps
`default_nettype none
module scirq_clk_gate_sel (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic gating_en,
    input wire logic in_sleep,
    input wire logic in_deep_sleep,
    input wire logic [7:0] run_en,
    input wire logic [7:0] sleep_en,
    input wire logic [7:0] deep_sleep_en,
    output logic [7:0] periph_clk_en
);
    genvar g;
    generate
        for (g = 0; g < scirq_pkg::NUM_PERIPH; g++) begin : g_per
            // deep-sleep settings stay held outside but are ignored while gating is off
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    periph_clk_en[g] <= 1'b0;
                end else if (!gating_en) begin
                    periph_clk_en[g] <= run_en[g];
                end else if (in_deep_sleep) begin
                    periph_clk_en[g] <= deep_sleep_en[g];
                end else if (in_sleep) begin
                    periph_clk_en[g] <= sleep_en[g];
                end else begin
                    periph_clk_en[g] <= run_en[g];
                end
            end
        end
    endgenerate

    property p_gate_off_runs;
        @(posedge clk_sys) disable iff (!rst_b)
        (!gating_en) |=> (periph_clk_en == $past(run_en));
    endproperty
    a_gate_off_runs: assert property (p_gate_off_runs) else $error("gating off but clocks differ");

    property p_gate_on_deep;
        @(posedge clk_sys) disable iff (!rst_b)
        (gating_en && in_deep_sleep) |=> (periph_clk_en == $past(deep_sleep_en));
    endproperty
    a_gate_on_deep: assert property (p_gate_on_deep) else $error("deep-sleep selection wrong");

    property p_gate_off_deep_ignored;
        @(posedge clk_sys) disable iff (!rst_b)
        (!gating_en && in_deep_sleep) |=> (periph_clk_en == $past(run_en));
    endproperty
    a_gate_off_deep_ignored: assert property (p_gate_off_deep_ignored) else $error("deep-sleep applied while off");
endmodule
`default_nettype wire

// ### verilog/scirq_osc_verify.sv
// one oscillator verification timer
// ref_tick and tgt_tick are one-cycle pulses already in the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module scirq_osc_verify (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic ref_running,
    input wire logic tgt_running,
    input wire logic ref_tick,
    input wire logic tgt_tick,
    input wire logic rearm,
    output logic fail_pulse
);
    scirq_pkg::scirq_vstate_t state_ff;
    scirq_pkg::scirq_vstate_t nxt_state;
    logic [3:0] cnt_ff;
    logic active;

    // counts reference ticks, so it only runs while both oscillators are on
    assign active = enable && ref_running && tgt_running;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            scirq_pkg::SCIRQ_V_IDLE: begin
                if (active) begin
                    nxt_state = scirq_pkg::SCIRQ_V_RUN;
                end
            end
            scirq_pkg::SCIRQ_V_RUN: begin
                if (!active) begin
                    nxt_state = scirq_pkg::SCIRQ_V_IDLE;
                end else if (ref_tick && !tgt_tick && cnt_ff == scirq_pkg::VERIFY_TICKS - 4'h1) begin
                    nxt_state = scirq_pkg::SCIRQ_V_FAIL;
                end
            end
            scirq_pkg::SCIRQ_V_FAIL: begin
                // stays reported until software rearms it
                if (rearm) begin
                    nxt_state = scirq_pkg::SCIRQ_V_IDLE;
                end
            end
            default: nxt_state = scirq_pkg::SCIRQ_V_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_ff <= scirq_pkg::SCIRQ_V_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || state_ff != scirq_pkg::SCIRQ_V_RUN || tgt_tick) begin
            cnt_ff <= 4'h0;
        end else if (ref_tick) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    assign fail_pulse = (state_ff == scirq_pkg::SCIRQ_V_RUN)
                        && (nxt_state == scirq_pkg::SCIRQ_V_FAIL);
endmodule
`default_nettype wire

// ### verilog/scirq_pkg.sv
// package for the system-control interrupt supervisor
// assumes a single 40 MHz system clock and synchronous active-low reset
package scirq_pkg;
    localparam int NUM_SRC = 7;
    localparam int NUM_PERIPH = 8;
    // event bit positions
    localparam int BIT_PLL_LOCK = 0;
    localparam int BIT_CUR_LIMIT = 1;
    localparam int BIT_IOSC_FAIL = 2;
    localparam int BIT_MOSC_FAIL = 3;
    localparam int BIT_REG_DROOP = 4;
    localparam int BIT_SUP_DROOP = 5;
    localparam int BIT_PLL_FAIL = 6;
    localparam logic [6:0] SRC_RESET = 7'h00;
    localparam logic [6:0] MASK_RESET = 7'h00;
    // regulator choice: code 0 = 2.25 V ... code 10 = 2.75 V, 50 mV steps
    localparam logic [3:0] VOLT_CODE_MAX = 4'ha;
    localparam logic [3:0] VOLT_RESET = 4'h5;
    // verification window in reference ticks: target silent this long means failed
    localparam logic [3:0] VERIFY_TICKS = 4'h8;
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

    typedef struct packed {
        logic pll_failure_event;
        logic supply_droop_event;
        logic regulator_droop_event;
        logic main_osc_failure_event;
        logic internal_osc_failure_event;
        logic regulator_current_limit_event;
        logic pll_locked_event;
    } scirq_src_t;

    typedef enum logic [1:0] {
        SCIRQ_V_IDLE = 2'b00,
        SCIRQ_V_RUN = 2'b01,
        SCIRQ_V_FAIL = 2'b10
    } scirq_vstate_t;
endpackage

// ### verilog/scirq_supervisor.sv
// system-control interrupt supervisor: event latching, masking, status, regulator,
// oscillator verification and sleep clock gating selection
// assumes all inputs are synchronous to clk_sys; oscillator ticks are pre-synchronised pulses
`timescale 1ns/1ps
`default_nettype none
// Operation
// - seven event sources: pll lock, current limit, two osc failures, two droops, pll fail
// - clear command drops exactly the sources selected in the bit mask
// - latched source stays set until software clears it
// - per-source enable mask; only enabled sources reach the interrupt
// - status readable raw or masked
// - all enabled sources are ORed into one interrupt line
// - internal oscillator verify timer, switchable, raises internal osc failure
// - internal osc timer counts main oscillator ticks, needs both running
// - main oscillator verify timer, switchable, raises main osc failure
// - main osc timer counts internal oscillator ticks, needs both running
// - clearing verification status rearms both timers
// - regulator fault control chooses reset or no reset on lost regulation
// - regulator voltage resets to 2.5 V, eleven steps 2.25 to 2.75 V
// - voltage read returns the held setting, not a measurement
// - clock gating off (default): peripherals clocked as in run mode
// - clock gating on: sleep and deep-sleep configurations apply
// - deep-sleep settings kept but unused while gating is off
module scirq_supervisor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire scirq_pkg::scirq_src_t hw_events,
    input wire logic [6:0] source_bit_mask,
    input wire logic clear_strobe,
    input wire logic enable_strobe,
    input wire logic disable_strobe,
    input wire logic masked_view_select,
    output scirq_pkg::scirq_src_t status_view,
    output logic sysctl_irq,
    input wire logic iosc_verify_wr,
    input wire logic mosc_verify_wr,
    input wire logic feature_enable_flag,
    input wire logic verify_clear_strobe,
    input wire logic main_osc_running,
    input wire logic int_osc_running,
    input wire logic main_osc_tick,
    input wire logic int_osc_tick,
    input wire logic regulator_cfg_wr,
    input wire logic regulator_fault_resets,
    input wire logic regulator_unregulated,
    output logic regulator_reset_req,
    input wire logic voltage_wr,
    input wire logic [3:0] regulator_voltage_choice,
    output logic [3:0] regulator_voltage_code,
    input wire logic gating_wr,
    input wire logic in_sleep,
    input wire logic in_deep_sleep,
    input wire logic [7:0] run_en,
    input wire logic [7:0] sleep_en,
    input wire logic [7:0] deep_sleep_en,
    output logic [7:0] periph_clk_en
);
    logic [6:0] src_ff;
    logic [6:0] nxt_src;
    logic [6:0] mask_ff;
    logic [6:0] set_vec;
    logic iosc_ver_en_ff;
    logic mosc_ver_en_ff;
    logic reg_rst_en_ff;
    logic gating_en_ff;
    logic iosc_fail;
    logic mosc_fail;

    // internal osc checked against main osc ticks
    scirq_osc_verify u_iosc_verify (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .enable(iosc_ver_en_ff),
        .ref_running(main_osc_running),
        .tgt_running(int_osc_running),
        .ref_tick(main_osc_tick),
        .tgt_tick(int_osc_tick),
        .rearm(verify_clear_strobe),
        .fail_pulse(iosc_fail)
    );

    // main osc checked against internal osc ticks
    scirq_osc_verify u_mosc_verify (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .enable(mosc_ver_en_ff),
        .ref_running(int_osc_running),
        .tgt_running(main_osc_running),
        .ref_tick(int_osc_tick),
        .tgt_tick(main_osc_tick),
        .rearm(verify_clear_strobe),
        .fail_pulse(mosc_fail)
    );

    always_comb begin
        set_vec = hw_events;
        set_vec[scirq_pkg::BIT_IOSC_FAIL] = hw_events.internal_osc_failure_event | iosc_fail;
        set_vec[scirq_pkg::BIT_MOSC_FAIL] = hw_events.main_osc_failure_event | mosc_fail;
        // set wins over a clear in the same cycle so no event is lost
        if (clear_strobe) begin
            nxt_src = (src_ff & ~source_bit_mask) | set_vec;
        end else begin
            nxt_src = src_ff | set_vec;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            src_ff <= scirq_pkg::SRC_RESET;
        end else begin
            src_ff <= nxt_src;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mask_ff <= scirq_pkg::MASK_RESET;
        end else if (enable_strobe) begin
            mask_ff <= mask_ff | source_bit_mask;
        end else if (disable_strobe) begin
            mask_ff <= mask_ff & ~source_bit_mask;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            status_view <= '0;
        end else if (masked_view_select) begin
            status_view <= src_ff & mask_ff;
        end else begin
            status_view <= src_ff;
        end
    end

    // the line follows the latch directly, so a late clear leaves it up (handler re-entry)
    assign sysctl_irq = |(src_ff & mask_ff);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            iosc_ver_en_ff <= 1'b0;
            mosc_ver_en_ff <= 1'b0;
        end else begin
            if (iosc_verify_wr) begin
                iosc_ver_en_ff <= feature_enable_flag;
            end
            if (mosc_verify_wr) begin
                mosc_ver_en_ff <= feature_enable_flag;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rst_en_ff <= 1'b0;
        end else if (regulator_cfg_wr) begin
            reg_rst_en_ff <= regulator_fault_resets;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            regulator_reset_req <= 1'b0;
        end else begin
            regulator_reset_req <= reg_rst_en_ff && regulator_unregulated;
        end
    end

    // out-of-range codes are ignored so the held value is always one of eleven steps
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            regulator_voltage_code <= scirq_pkg::VOLT_RESET;
        end else if (voltage_wr && regulator_voltage_choice <= scirq_pkg::VOLT_CODE_MAX) begin
            regulator_voltage_code <= regulator_voltage_choice;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            gating_en_ff <= 1'b0;
        end else if (gating_wr) begin
            gating_en_ff <= feature_enable_flag;
        end
    end

    scirq_clk_gate_sel u_gate (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .gating_en(gating_en_ff),
        .in_sleep(in_sleep),
        .in_deep_sleep(in_deep_sleep),
        .run_en(run_en),
        .sleep_en(sleep_en),
        .deep_sleep_en(deep_sleep_en),
        .periph_clk_en(periph_clk_en)
    );

    property p_clear_drops;
        @(posedge clk_sys) disable iff (!rst_b)
        (clear_strobe && source_bit_mask[0] && !hw_events[0]) |=> !src_ff[0];
    endproperty
    a_clear_drops: assert property (p_clear_drops) else $error("cleared source still set");

    property p_clear_zero_keeps;
        @(posedge clk_sys) disable iff (!rst_b)
        (clear_strobe && !source_bit_mask[3] && src_ff[3]) |=> src_ff[3];
    endproperty
    a_clear_zero_keeps: assert property (p_clear_zero_keeps) else $error("unselected source lost");

    property p_sticky;
        @(posedge clk_sys) disable iff (!rst_b)
        (src_ff[5] && !clear_strobe) |=> src_ff[5];
    endproperty
    a_sticky: assert property (p_sticky) else $error("source dropped without clear");

    property p_event_latches;
        @(posedge clk_sys) disable iff (!rst_b)
        hw_events.pll_failure_event |=> src_ff[scirq_pkg::BIT_PLL_FAIL];
    endproperty
    a_event_latches: assert property (p_event_latches) else $error("event not latched");

    property p_irq_mask;
        @(posedge clk_sys) disable iff (!rst_b)
        (mask_ff == 7'h00) |-> !sysctl_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq without enabled source");

    property p_irq_up;
        @(posedge clk_sys) disable iff (!rst_b)
        (src_ff[1] && mask_ff[1]) |-> sysctl_irq;
    endproperty
    a_irq_up: assert property (p_irq_up) else $error("enabled source not on irq");

    property p_masked_view;
        @(posedge clk_sys) disable iff (!rst_b)
        masked_view_select |=> (status_view == ($past(src_ff) & $past(mask_ff)));
    endproperty
    a_masked_view: assert property (p_masked_view) else $error("masked status wrong");

    property p_volt_reset;
        @(posedge clk_sys)
        !rst_b |=> (regulator_voltage_code == scirq_pkg::VOLT_RESET);
    endproperty
    a_volt_reset: assert property (p_volt_reset) else $error("voltage not at default");

    property p_reg_noreset;
        @(posedge clk_sys) disable iff (!rst_b)
        !reg_rst_en_ff |=> !regulator_reset_req;
    endproperty
    a_reg_noreset: assert property (p_reg_noreset) else $error("reset despite no-reset mode");

    property p_set_beats_clear;
        @(posedge clk_sys) disable iff (!rst_b)
        (clear_strobe && source_bit_mask[0] && hw_events.pll_locked_event) |=> src_ff[0];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("event lost to clear");

    property p_raw_view;
        @(posedge clk_sys) disable iff (!rst_b)
        !masked_view_select |=> (status_view == $past(src_ff));
    endproperty
    a_raw_view: assert property (p_raw_view) else $error("raw status wrong");

    property p_mask_enable;
        @(posedge clk_sys) disable iff (!rst_b)
        enable_strobe |=> ((mask_ff & $past(source_bit_mask)) == $past(source_bit_mask));
    endproperty
    a_mask_enable: assert property (p_mask_enable) else $error("enable did not set mask");

    property p_mask_disable;
        @(posedge clk_sys) disable iff (!rst_b)
        (disable_strobe && !enable_strobe) |=> ((mask_ff & $past(source_bit_mask)) == 7'h00);
    endproperty
    a_mask_disable: assert property (p_mask_disable) else $error("disable left mask set");

    property p_iosc_fail_sets;
        @(posedge clk_sys) disable iff (!rst_b)
        iosc_fail |=> src_ff[scirq_pkg::BIT_IOSC_FAIL];
    endproperty
    a_iosc_fail_sets: assert property (p_iosc_fail_sets) else $error("internal osc fail lost");

    property p_mosc_fail_sets;
        @(posedge clk_sys) disable iff (!rst_b)
        mosc_fail |=> src_ff[scirq_pkg::BIT_MOSC_FAIL];
    endproperty
    a_mosc_fail_sets: assert property (p_mosc_fail_sets) else $error("main osc fail lost");

    property p_two_osc;
        @(posedge clk_sys) disable iff (!rst_b)
        (!main_osc_running || !int_osc_running) |-> !(iosc_fail || mosc_fail);
    endproperty
    a_two_osc: assert property (p_two_osc) else $error("fail with osc off");

    property p_volt_held;
        @(posedge clk_sys) disable iff (!rst_b)
        !voltage_wr |=> $stable(regulator_voltage_code);
    endproperty
    a_volt_held: assert property (p_volt_held) else $error("voltage changed unwritten");

    property p_reg_reset_follows;
        @(posedge clk_sys) disable iff (!rst_b)
        (reg_rst_en_ff && regulator_unregulated) |=> regulator_reset_req;
    endproperty
    a_reg_reset_follows: assert property (p_reg_reset_follows) else $error("no reset request");
endmodule
`default_nettype wire
